// File: rtl/pbm_pkg.sv
package pbm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PBM_PINS     = 8;
  localparam int PBM_LOW_PINS = 4;
  localparam int PBM_CLK_PINS = 4;
  localparam int PBM_AW       = 4;
  localparam int PBM_DW       = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [PBM_AW-1:0] PBM_OFS_DATA_OUT  = 4'h0;
  localparam logic [PBM_AW-1:0] PBM_OFS_DIRECTION = 4'h1;
  localparam logic [PBM_AW-1:0] PBM_OFS_PERIPH_EN = 4'h2;
  localparam logic [PBM_AW-1:0] PBM_OFS_PULLUP_EN = 4'h3;
  localparam logic [PBM_AW-1:0] PBM_OFS_CLK_OSEL  = 4'h4;
  localparam logic [PBM_AW-1:0] PBM_OFS_BUS_CTRL  = 4'h5;
  localparam logic [PBM_AW-1:0] PBM_OFS_PIN_IN    = 4'h6;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int PBM_BIT_DRIVE_KEEP = 0;

  localparam logic [PBM_PINS-1:0]     PBM_RST_DATA_OUT  = 8'h00;
  localparam logic [PBM_PINS-1:0]     PBM_RST_DIRECTION = 8'h00;
  localparam logic [PBM_PINS-1:0]     PBM_RST_PULLUP_EN = 8'hff;
  localparam logic [PBM_CLK_PINS-1:0] PBM_RST_CLK_OSEL  = 4'h0;
  localparam logic                    PBM_RST_DRIVE     = 1'b0;
  localparam logic [PBM_PINS-1:0]     PBM_ALL_ON        = 8'hff;
  localparam logic [PBM_PINS-1:0]     PBM_ALL_OFF       = 8'h00;
  localparam logic [PBM_LOW_PINS-1:0] PBM_LOW_ON        = 4'hf;
  localparam logic [PBM_LOW_PINS-1:0] PBM_LOW_OFF       = 4'h0;
  localparam logic [PBM_CLK_PINS-1:0] PBM_UP_OFF        = 4'h0;

  localparam logic [PBM_DW-1:0] PBM_RD_ZERO = 16'h0000;

endpackage : pbm_pkg

// File: rtl/pbm_port_b_mux.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps

// What this block does
// - Non-peripheral pins are software GPIO inputs or outputs per pin.
// - Lower four pins in address mode carry address bits 16 to 19.
// - Upper four pins in address mode carry address bits 20 to 23.
// - Idle bus: address pins float or stay driven per bus drive bit.
// - Lower pin reset function set by boot, memory, security straps.
// - Peripheral-enable write overrides the reset function.
// - Clearing a pull-up enable bit switches that pin's pull-up off.
// - Upper four pins are GPIO after reset.
// - Clock monitors on pins 4..7: prescaled, main, second, oscillator.
// - Peripheral-enable bit hands each upper pin to a peripheral.
// - Clock-out select picks address or clock for each handed-over upper pin.
// - Pull-up enable bit n controls pin n.
module pbm_port_b_mux (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic [pbm_pkg::PBM_AW-1:0]  reg_addr,
  input  wire logic [pbm_pkg::PBM_DW-1:0]  reg_wdata,
  input  wire logic                        reg_we,
  input  wire logic                        reg_re,
  output logic      [pbm_pkg::PBM_DW-1:0]  reg_rdata,
  input  wire logic                        boot_source_select,
  input  wire logic                        memory_width_strap,
  input  wire logic                        flash_secure,
  input  wire logic                        ext_bus_active,
  input  wire logic [pbm_pkg::PBM_PINS-1:0] ext_addr_upper,
  input  wire logic                        prescaler_clock,
  input  wire logic                        system_clock_main,
  input  wire logic                        system_clock_second,
  input  wire logic                        oscillator_clock,
  input  wire logic [pbm_pkg::PBM_PINS-1:0] pin_in,
  output logic      [pbm_pkg::PBM_PINS-1:0] pin_out,
  output logic      [pbm_pkg::PBM_PINS-1:0] pin_oe_n,
  output logic      [pbm_pkg::PBM_PINS-1:0] pin_pullup
);
  import pbm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PBM_PINS-1:0]     data_out;
    logic [PBM_PINS-1:0]     direction;
    logic [PBM_PINS-1:0]     portb_peripheral_enable;
    logic [PBM_PINS-1:0]     portb_pullup_enable;
    logic [PBM_CLK_PINS-1:0] clock_out_select;
    logic                    bus_drive_keep;
    logic [PBM_DW-1:0]       rdata;
    logic [PBM_PINS-1:0]     pin_out;
    logic [PBM_PINS-1:0]     pin_oe_n;
    logic [PBM_PINS-1:0]     pin_pullup;
  } pbm_state_s;

  pbm_state_s st;
  pbm_state_s next_st;

  // Strap decode for the lower pins: address on an unsecured part when
  // booting externally or when a wide external memory is strapped
  function automatic logic [PBM_LOW_PINS-1:0] pbm_low_reset_per(
    input logic boot_ext,
    input logic mem_wide,
    input logic secure
  );
    logic addr_mode;
    addr_mode = (boot_ext | mem_wide) & ~secure;
    return addr_mode ? PBM_LOW_ON : PBM_LOW_OFF;
  endfunction : pbm_low_reset_per

  function automatic logic [PBM_DW-1:0] pbm_zext8(
    input logic [PBM_PINS-1:0] v
  );
    return {{(PBM_DW-PBM_PINS){1'b0}}, v};
  endfunction : pbm_zext8

  logic [PBM_CLK_PINS-1:0] mon_clk;
  assign mon_clk = {oscillator_clock, system_clock_second,
                    system_clock_main, prescaler_clock};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic addr_drive;
    logic sel_clk;
    addr_drive = 1'b0;
    sel_clk    = 1'b0;
    next_st    = st;
    next_st.rdata = PBM_RD_ZERO;

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    if (reg_we) begin
      unique case (reg_addr)
        PBM_OFS_DATA_OUT:  next_st.data_out  = reg_wdata[PBM_PINS-1:0];
        PBM_OFS_DIRECTION: next_st.direction = reg_wdata[PBM_PINS-1:0];
        PBM_OFS_PERIPH_EN: begin
          next_st.portb_peripheral_enable = reg_wdata[PBM_PINS-1:0];
        end
        PBM_OFS_PULLUP_EN: begin
          next_st.portb_pullup_enable = reg_wdata[PBM_PINS-1:0];
        end
        PBM_OFS_CLK_OSEL: begin
          next_st.clock_out_select = reg_wdata[PBM_CLK_PINS-1:0];
        end
        PBM_OFS_BUS_CTRL: begin
          next_st.bus_drive_keep = reg_wdata[PBM_BIT_DRIVE_KEEP];
        end
        default: ;
      endcase
    end

    // --------------------------------------------------------------
    // Register reads, one cycle of data then zero
    // --------------------------------------------------------------
    if (reg_re) begin
      unique case (reg_addr)
        PBM_OFS_DATA_OUT:  next_st.rdata = pbm_zext8(st.data_out);
        PBM_OFS_DIRECTION: next_st.rdata = pbm_zext8(st.direction);
        PBM_OFS_PERIPH_EN: begin
          next_st.rdata = pbm_zext8(st.portb_peripheral_enable);
        end
        PBM_OFS_PULLUP_EN: begin
          next_st.rdata = pbm_zext8(st.portb_pullup_enable);
        end
        PBM_OFS_CLK_OSEL: begin
          next_st.rdata = {{(PBM_DW-PBM_CLK_PINS){1'b0}}, st.clock_out_select};
        end
        PBM_OFS_BUS_CTRL: begin
          next_st.rdata = {{(PBM_DW-1){1'b0}}, st.bus_drive_keep};
        end
        PBM_OFS_PIN_IN:    next_st.rdata = pbm_zext8(pin_in);
        default:           next_st.rdata = PBM_RD_ZERO;
      endcase
    end

    // --------------------------------------------------------------
    // Pin multiplexer
    // --------------------------------------------------------------
    addr_drive = ext_bus_active | st.bus_drive_keep;
    for (int i = 0; i < PBM_PINS; i++) begin
      if (!st.portb_peripheral_enable[i]) begin
        next_st.pin_out[i]  = st.data_out[i];
        next_st.pin_oe_n[i] = ~st.direction[i];
      end else begin
        sel_clk = 1'b0;
        if (i >= PBM_LOW_PINS) begin
          sel_clk = st.clock_out_select[i-PBM_LOW_PINS];
        end
        if (sel_clk) begin
          next_st.pin_out[i]  = mon_clk[i-PBM_LOW_PINS];
          next_st.pin_oe_n[i] = 1'b0;
        end else begin
          next_st.pin_out[i]  = ext_addr_upper[i];
          next_st.pin_oe_n[i] = ~addr_drive;
        end
      end
      // Pull-up only acts while the driver is off
      next_st.pin_pullup[i] = st.portb_pullup_enable[i] &
                              next_st.pin_oe_n[i];
    end

    // --------------------------------------------------------------
    // Reset last so it overrides every path above
    // --------------------------------------------------------------
    if (!reset_n) begin
      next_st.data_out            = PBM_RST_DATA_OUT;
      next_st.direction           = PBM_RST_DIRECTION;
      next_st.portb_peripheral_enable = {PBM_UP_OFF,
        pbm_low_reset_per(boot_source_select, memory_width_strap,
                          flash_secure)};
      next_st.portb_pullup_enable = PBM_RST_PULLUP_EN;
      next_st.clock_out_select    = PBM_RST_CLK_OSEL;
      next_st.bus_drive_keep      = PBM_RST_DRIVE;
      next_st.rdata               = PBM_RD_ZERO;
      next_st.pin_out             = PBM_ALL_OFF;
      next_st.pin_oe_n            = PBM_ALL_ON;
      next_st.pin_pullup          = PBM_ALL_ON;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata  = st.rdata;
  assign pin_out    = st.pin_out;
  assign pin_oe_n   = st.pin_oe_n;
  assign pin_pullup = st.pin_pullup;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_gpio_drive: assert property (
    ##1 (((st.pin_out ^ $past(st.data_out)) | st.pin_oe_n) &
     $past(~st.portb_peripheral_enable & st.direction)) == PBM_ALL_OFF)
    else $error("gpio output pin not driven with data");

  a_gpio_input: assert property (
    ##1 ((~st.pin_oe_n) &
     $past(~st.portb_peripheral_enable & ~st.direction)) == PBM_ALL_OFF)
    else $error("gpio input pin is driven");

  a_addr_low: assert property (
    reset_n |=> (((st.pin_out[PBM_LOW_PINS-1:0] ^
      $past(ext_addr_upper[PBM_LOW_PINS-1:0])) &
     $past(st.portb_peripheral_enable[PBM_LOW_PINS-1:0])) == PBM_LOW_OFF))
    else $error("lower pin lost address bit");

  a_addr_high: assert property (
    ##1 (((st.pin_out[PBM_PINS-1:PBM_LOW_PINS] ^
      $past(ext_addr_upper[PBM_PINS-1:PBM_LOW_PINS])) &
     $past(st.portb_peripheral_enable[PBM_PINS-1:PBM_LOW_PINS] &
           ~st.clock_out_select)) == PBM_UP_OFF))
    else $error("upper pin lost address bit");

  a_idle_float: assert property (
    (!ext_bus_active && !st.bus_drive_keep &&
     st.portb_peripheral_enable[0]) |=> st.pin_oe_n[0])
    else $error("address pin driven on idle bus without keep");

  a_idle_keep: assert property (
    (st.bus_drive_keep && st.portb_peripheral_enable[0]) |=> !st.pin_oe_n[0])
    else $error("address pin floats although keep set");

  a_reset_upper: assert property (
    $rose(reset_n) |-> (st.portb_peripheral_enable[PBM_PINS-1:PBM_LOW_PINS]
                        == PBM_UP_OFF) [*2])
    else $error("upper pins not gpio after reset");

  a_per_write: assert property (
    (reg_we && reg_addr == PBM_OFS_PERIPH_EN) |=>
      st.portb_peripheral_enable == $past(reg_wdata[PBM_PINS-1:0]))
    else $error("peripheral enable write not taken");

  a_clk_mon: assert property (
    (st.portb_peripheral_enable[PBM_PINS-1] && st.clock_out_select[3]) |=>
      (st.pin_out[PBM_PINS-1] == $past(oscillator_clock) && !st.pin_oe_n[7]))
    else $error("pin seven not showing oscillator clock");

  a_pullup_off: assert property (
    (reg_we && reg_addr == PBM_OFS_PULLUP_EN && !reg_wdata[2]) |-> ##2
      !st.pin_pullup[2])
    else $error("pull-up still on after clear");

  a_reset_pins: assert property (
    $rose(reset_n) |-> (st.pin_oe_n == PBM_ALL_ON &&
                        st.pin_pullup == PBM_ALL_ON))
    else $error("pins not released as inputs with pull-up");

  a_reset_straps: assert property (
    $rose(reset_n) |-> (st.portb_peripheral_enable[PBM_LOW_PINS-1:0] ==
      {PBM_LOW_PINS{($past(boot_source_select) |
                     $past(memory_width_strap)) & ~$past(flash_secure)}}))
    else $error("lower pin function does not follow straps");

  a_pullup_mask: assert property (
    reset_n |=> ((st.pin_pullup & ~$past(st.portb_pullup_enable)) ==
                 PBM_ALL_OFF))
    else $error("pull-up on although its enable bit is clear");

  a_up_addr: assert property (
    (st.portb_peripheral_enable[4] && !st.clock_out_select[0] &&
     st.bus_drive_keep) |=>
      (st.pin_out[4] == $past(ext_addr_upper[4]) && !st.pin_oe_n[4]))
    else $error("pin four not showing address bit");

  a_clk_pre: assert property (
    (st.portb_peripheral_enable[4] && st.clock_out_select[0]) |=>
      (st.pin_out[4] == $past(prescaler_clock) && !st.pin_oe_n[4]))
    else $error("pin four not showing prescaled clock");

  a_clk_main: assert property (
    (st.portb_peripheral_enable[5] && st.clock_out_select[1]) |=>
      (st.pin_out[5] == $past(system_clock_main) && !st.pin_oe_n[5]))
    else $error("pin five not showing main clock");

  a_clk_second: assert property (
    (st.portb_peripheral_enable[6] && st.clock_out_select[2]) |=>
      (st.pin_out[6] == $past(system_clock_second) && !st.pin_oe_n[6]))
    else $error("pin six not showing second clock");

  c_clk_out:  cover property (st.portb_peripheral_enable[4] &&
                              st.clock_out_select[0] && !st.pin_oe_n[4]);
  c_addr_out: cover property (st.portb_peripheral_enable[0] &&
                              !st.pin_oe_n[0]);
  c_gpio_out: cover property (!st.portb_peripheral_enable[5] &&
                              !st.pin_oe_n[5]);
  c_read_pin: cover property (reg_re && reg_addr == PBM_OFS_PIN_IN);
  c_strap_gpio: cover property ($rose(reset_n) &&
                                !st.portb_peripheral_enable[0]);

endmodule : pbm_port_b_mux

// File: sim/pbm_ext_mem.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Pad world and external memory seen from the pins
// ----------------------------------------------------------------
module pbm_ext_mem (
  input  wire logic                         clk,
  input  wire logic                         mem_req,
  input  wire logic [pbm_pkg::PBM_PINS-1:0] pin_out,
  input  wire logic [pbm_pkg::PBM_PINS-1:0] pin_oe_n,
  input  wire logic [pbm_pkg::PBM_PINS-1:0] pin_pullup,
  input  wire logic [pbm_pkg::PBM_PINS-1:0] ext_en,
  input  wire logic [pbm_pkg::PBM_PINS-1:0] ext_val,
  output logic      [pbm_pkg::PBM_PINS-1:0] pad,
  output logic      [pbm_pkg::PBM_PINS-1:0] seen_addr
);
  import pbm_pkg::*;

  logic [PBM_PINS-1:0] last;

  // Floating pins toggle so a stale level never looks valid
  always_comb begin
    for (int i = 0; i < PBM_PINS; i++) begin
      if (!pin_oe_n[i]) begin
        pad[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pad[i] = ext_val[i];
      end else if (pin_pullup[i]) begin
        pad[i] = 1'b1;
      end else begin
        pad[i] = ~last[i];
      end
    end
  end

  initial last = '0;
  initial seen_addr = '0;

  // Memory latches the upper address while an access runs
  always @(posedge clk) begin
    last <= pad;
    if (mem_req) begin
      seen_addr <= pad;
    end
  end
endmodule : pbm_ext_mem

// File: sim/pbm_port_b_mux_bench.sv
`timescale 1ns/1ps

module pbm_port_b_mux_bench;
  import pbm_pkg::*;

  logic                clk, reset_n, reg_we, reg_re, boot, mem_w, secure;
  logic                bus_act;
  logic [PBM_AW-1:0]   reg_addr;
  logic [PBM_DW-1:0]   reg_wdata, reg_rdata;
  logic [PBM_PINS-1:0] ext_addr, pin_in, pin_out, pin_oe_n, pin_pullup;
  logic [PBM_PINS-1:0] ext_en, ext_val, seen_addr;
  logic [3:0]          mon;
  int                  n_errors, tests_run;

  pbm_port_b_mux DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .boot_source_select(boot),
    .memory_width_strap(mem_w), .flash_secure(secure),
    .ext_bus_active(bus_act), .ext_addr_upper(ext_addr),
    .prescaler_clock(mon[0]), .system_clock_main(mon[1]),
    .system_clock_second(mon[2]), .oscillator_clock(mon[3]),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup));

  pbm_ext_mem mem (.clk(clk), .mem_req(bus_act), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .ext_en(ext_en),
    .ext_val(ext_val), .pad(pin_in), .seen_addr(seen_addr));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic chk_reg(input string n, input logic [PBM_DW-1:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string n, input logic [PBM_PINS-1:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk_pin

  task automatic wr(input logic [PBM_AW-1:0] a, input logic [PBM_DW-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [PBM_AW-1:0] a, input logic [PBM_DW-1:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk);
    reg_re   <= 1'b0;
    #1 chk_reg("reg_rdata", e, reg_rdata);
    @(posedge clk);
    #1 chk_reg("reg_rdata idle", PBM_RD_ZERO, reg_rdata);
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {reset_n, reg_we, reg_re, mem_w, secure, bus_act} = '0;
    {reg_addr, reg_wdata, mon, ext_en, ext_val} = '0;
    boot = 1'b1;
    ext_addr = 8'hc5;
    n_errors = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk_pin("oe_n in reset", PBM_ALL_ON, pin_oe_n);
    chk_pin("pullup in reset", PBM_ALL_ON, pin_pullup);
    settle();
    rd(PBM_OFS_PERIPH_EN, 16'h000f);
    rd(PBM_OFS_PULLUP_EN, 16'h00ff);
    rd(PBM_OFS_CLK_OSEL, 16'h0000);
    rd(PBM_OFS_BUS_CTRL, 16'h0000);
    chk_pin("oe_n idle", PBM_ALL_ON, pin_oe_n);
    @(posedge clk);
    bus_act <= 1'b1;
    settle();
    chk_pin("pin_out", 8'h05, pin_out);
    chk_pin("oe_n", 8'hf0, pin_oe_n);
    chk_pin("memory address", 8'hf5, seen_addr);
    @(posedge clk);
    bus_act <= 1'b0;
    wr(PBM_OFS_BUS_CTRL, 16'h0001);
    settle();
    chk_pin("oe_n kept", 8'hf0, pin_oe_n);
    wr(PBM_OFS_PERIPH_EN, 16'h00f0);
    wr(PBM_OFS_DIRECTION, 16'h00ff);
    wr(PBM_OFS_DATA_OUT, 16'h000a);
    wr(PBM_OFS_PIN_IN, 16'h0000);
    settle();
    chk_pin("pin_out", 8'hca, pin_out);
    chk_pin("oe_n", 8'h00, pin_oe_n);
    rd(PBM_OFS_PIN_IN, 16'h00ca);
    rd(4'hf, 16'h0000);
    wr(PBM_OFS_CLK_OSEL, 16'h000f);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      mon <= 4'(1 << k);
      settle();
      chk_pin("clock pins", {4'(1 << k), 4'ha}, pin_out);
    end
    @(posedge clk);
    mon <= 4'h0;
    wr(PBM_OFS_CLK_OSEL, 16'h0005);
    settle();
    chk_pin("mixed pins", 8'h8a, pin_out);
    wr(PBM_OFS_PERIPH_EN, 16'h0000);
    settle();
    chk_pin("gpio pins", 8'h0a, pin_out);
    chk_pin("gpio oe_n", 8'h00, pin_oe_n);
    wr(PBM_OFS_DIRECTION, 16'h0000);
    wr(PBM_OFS_PULLUP_EN, 16'h007a);
    ext_en  <= 8'hff;
    ext_val <= 8'ha5;
    settle();
    chk_pin("pullup", 8'h7a, pin_pullup);
    chk_pin("oe_n inputs", PBM_ALL_ON, pin_oe_n);
    rd(PBM_OFS_PIN_IN, 16'h00a5);
    @(posedge clk);
    reset_n <= 1'b0;
    secure  <= 1'b1;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk_pin("pullup in reset", PBM_ALL_ON, pin_pullup);
    settle();
    rd(PBM_OFS_PERIPH_EN, 16'h0000);
    test_done();
  end

  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule : pbm_port_b_mux_bench
